// file: fasc_pkg.sv
// Purpose: Shared constants for the fault alarm and shutdown control block
// Assumes: 10 MHz system clock, byte-wide register port
// Notes: Offsets are the register port addresses
package fasc_pkg;
   // Register offsets
   localparam logic [7:0] FAULT_TARGET_MASK_A_OFS = 8'h05;
   localparam logic [7:0] FAULT_TARGET_MASK_B_OFS = 8'h06;
   localparam logic [7:0] FAULT_ALARM_STATUS_OFS = 8'h19;
   // Mask field positions
   localparam int EXT_ALARM_TWO_EN_BIT = 5;
   localparam int EXT_ALARM_ONE_EN_BIT = 4;
   localparam int CURRENT_ALARM_EN_BIT = 3;
   localparam int OPTICAL_ALARM_EN_BIT = 2;
   localparam int TEMPERATURE_ALARM_EN_BIT = 7;
   // Status field positions
   localparam int ST_OPTICAL_BIT = 0;
   localparam int ST_CURRENT_BIT = 1;
   localparam int ST_EXT_ONE_BIT = 2;
   localparam int ST_EXT_TWO_BIT = 3;
   localparam int ST_TEMPERATURE_BIT = 4;
   localparam int ALARM_COUNT = 5;
   // Values after reset
   localparam logic [7:0] MASK_A_RESET = 8'h00;
   localparam logic [7:0] MASK_B_RESET = 8'h00;
   localparam logic [7:0] STATUS_RESET = 8'h00;
   // Pin synchroniser depth
   localparam int SYNC_STAGES = 2;
   // Timing
   localparam int CLK_PERIOD_NS = 100;
   localparam int EXT_DETECT_NS = 1000;
   localparam int EXT_DETECT_CYCLES = (EXT_DETECT_NS / CLK_PERIOD_NS < 1) ? 1 :
                                      EXT_DETECT_NS / CLK_PERIOD_NS;
   // Selection of the spare DAC
   typedef enum logic {
      fasc_spare_current_one,
      fasc_spare_voltage
   } fasc_spare_type;
endpackage

// file: fasc_sync.sv
// Purpose: Multi-bit level synchroniser for asynchronous pins
// Assumes: Each bit is an independent level
// Notes: First stage is read only by the next stage
module fasc_sync #(
   parameter int WIDTH = 1,
   parameter int STAGES = 2
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [WIDTH-1:0] d,
   output logic [WIDTH-1:0] q
);
   logic [WIDTH-1:0] stage_r [STAGES];

   // Shift chain of flip-flops
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         for (int i = 0; i < STAGES; i++) begin
            stage_r[i] <= '0;
         end
      end else begin
         stage_r[0] <= d;
         for (int i = 1; i < STAGES; i++) begin
            stage_r[i] <= stage_r[i-1];
         end
      end
   end

   assign q = stage_r[STAGES-1];
endmodule

// file: fasc_top.sv
// Purpose: Alarm collection, transmit-fault output and shutdown control
// Assumes: Alarm detectors are upstream; pins are asynchronous to clk
// Notes: Status bits clear on read; a new alarm in that cycle wins
// Overview of operation
// - Flag alarm one when pin differs from polarity
// - Shared pin is alarm two in allowed modes
// - Polarity 0 means high alarm, 1 low
// - Fault is OR of enabled alarms
// - Mask bit positions for each alarm
// - Detected alarm sets its status bit
// - SFP mode: fault latches and shuts down
// - SFP mode: disable request freezes fault level
// - Disable release clears latched fault
// - Adjustment mode blocks fault shutdown
// - Non-SFP mode: fault follows, no fault shutdown
// - Current alarm output inactive in shutdown
// - Disable pin high forces shutdown
// - SFP fault without disable shuts down
// - Current DACs float, voltage DAC clamped
// - Spare DAC exempt from shutdown
// - Feed-forward keeps updating in shutdown
// - Feedback held, reset after fault release
// - Alarm detection continues during shutdown
// - External alarm seen within one microsecond
module fasc_top (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic tx_disable,
   input wire logic external_alarm_one,
   input wire logic modulation_control_pin,
   input wire logic optical_alarm,
   input wire logic current_alarm,
   input wire logic temperature_alarm,
   input wire logic ext_alarm_one_polarity,
   input wire logic ext_alarm_two_polarity,
   input wire logic power_leveling_one_enable,
   input wire logic sfp_support_select,
   input wire logic adjustment_mode,
   input wire fasc_pkg::fasc_spare_type spare_dac_assignment,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   output logic tx_fault,
   output logic shutdown,
   output logic current_alarm_out,
   output logic current_dac_one_hiz,
   output logic current_dac_two_hiz,
   output logic voltage_dac_clamp,
   output logic feed_forward_update,
   output logic feedback_hold,
   output logic feedback_reset
);
   logic [2:0] pins_s;
   logic dis_s;
   logic ext1_s;
   logic ext2_s;
   logic dis_d_r;
   logic [7:0] mask_a_r;
   logic [7:0] mask_b_r;
   logic [7:0] status_r;
   logic [7:0] status_nxt;
   logic [7:0] rdata_nxt;
   logic fault_latch_r;
   logic fault_latch_nxt;
   logic tx_fault_r;
   logic tx_fault_nxt;
   logic shutdown_r;
   logic shutdown_nxt;
   logic sfp_on;
   logic ext2_as_alarm;
   logic ext1_alarm;
   logic ext2_alarm;
   logic [4:0] alarms;
   logic [4:0] enables;
   logic fault_any;
   logic dis_release;
   logic fault_shutdown_r;

   // Pin synchronisers
   fasc_sync #(.WIDTH(3), .STAGES(fasc_pkg::SYNC_STAGES)) u_sync (
      .clk(clk),
      .rst_n(rst_n),
      .d({tx_disable, external_alarm_one, modulation_control_pin}),
      .q(pins_s)
   );

   // Alarm decode
   assign dis_s = pins_s[2];
   assign ext1_s = pins_s[1];
   assign ext2_s = pins_s[0];
   assign sfp_on = ~sfp_support_select;
   assign ext2_as_alarm = ~power_leveling_one_enable | sfp_on;
   assign ext1_alarm = ext1_s ^ ext_alarm_one_polarity;
   assign ext2_alarm = ext2_as_alarm & (ext2_s ^ ext_alarm_two_polarity);

   // Alarm vector in status bit order
   assign alarms[fasc_pkg::ST_OPTICAL_BIT] = optical_alarm;
   assign alarms[fasc_pkg::ST_CURRENT_BIT] = current_alarm;
   assign alarms[fasc_pkg::ST_EXT_ONE_BIT] = ext1_alarm;
   assign alarms[fasc_pkg::ST_EXT_TWO_BIT] = ext2_alarm;
   assign alarms[fasc_pkg::ST_TEMPERATURE_BIT] = temperature_alarm;

   // Fault target enables
   assign enables[fasc_pkg::ST_OPTICAL_BIT] = mask_a_r[fasc_pkg::OPTICAL_ALARM_EN_BIT];
   assign enables[fasc_pkg::ST_CURRENT_BIT] = mask_a_r[fasc_pkg::CURRENT_ALARM_EN_BIT];
   assign enables[fasc_pkg::ST_EXT_ONE_BIT] = mask_a_r[fasc_pkg::EXT_ALARM_ONE_EN_BIT];
   assign enables[fasc_pkg::ST_EXT_TWO_BIT] = mask_a_r[fasc_pkg::EXT_ALARM_TWO_EN_BIT];
   assign enables[fasc_pkg::ST_TEMPERATURE_BIT] =
      mask_b_r[fasc_pkg::TEMPERATURE_ALARM_EN_BIT];
   assign fault_any = |(alarms & enables);

   // Fault latch and shutdown decisions
   assign dis_release = dis_d_r & ~dis_s;
   assign fault_latch_nxt = dis_release ? 1'b0 :
                            dis_s ? fault_latch_r :
                            (fault_latch_r | fault_any);
   assign tx_fault_nxt = sfp_on ? fault_latch_nxt : fault_any;
   assign shutdown_nxt = dis_s | (sfp_on & fault_latch_nxt & ~adjustment_mode);

   // Status: alarm sets win over clear on read
   assign status_nxt = ((reg_rd && reg_addr == fasc_pkg::FAULT_ALARM_STATUS_OFS) ?
                        8'h00 : status_r) | {3'h0, alarms};

   // Read mux
   assign rdata_nxt = (reg_addr == fasc_pkg::FAULT_TARGET_MASK_A_OFS) ? mask_a_r :
                      (reg_addr == fasc_pkg::FAULT_TARGET_MASK_B_OFS) ? mask_b_r :
                      (reg_addr == fasc_pkg::FAULT_ALARM_STATUS_OFS) ? status_r : 8'h00;

   // Register file
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         mask_a_r <= fasc_pkg::MASK_A_RESET;
         mask_b_r <= fasc_pkg::MASK_B_RESET;
         status_r <= fasc_pkg::STATUS_RESET;
         reg_rdata <= 8'h00;
      end else begin
         if (reg_wr && reg_addr == fasc_pkg::FAULT_TARGET_MASK_A_OFS) begin
            mask_a_r <= reg_wdata;
         end
         if (reg_wr && reg_addr == fasc_pkg::FAULT_TARGET_MASK_B_OFS) begin
            mask_b_r <= reg_wdata;
         end
         status_r <= status_nxt;
         if (reg_rd) begin
            reg_rdata <= rdata_nxt;
         end
      end
   end

   // Fault and shutdown state
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         dis_d_r <= 1'b0;
         fault_latch_r <= 1'b0;
         tx_fault_r <= 1'b0;
         shutdown_r <= 1'b0;
         fault_shutdown_r <= 1'b0;
      end else begin
         dis_d_r <= dis_s;
         fault_latch_r <= sfp_on ? fault_latch_nxt : 1'b0;
         tx_fault_r <= tx_fault_nxt;
         shutdown_r <= shutdown_nxt;
         fault_shutdown_r <= dis_release ? 1'b0 :
                             (fault_shutdown_r | (sfp_on & fault_latch_nxt));
      end
   end

   // Outputs straight from flip-flops
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         current_alarm_out <= 1'b0;
         current_dac_one_hiz <= 1'b0;
         current_dac_two_hiz <= 1'b0;
         voltage_dac_clamp <= 1'b0;
         feed_forward_update <= 1'b0;
         feedback_hold <= 1'b0;
         feedback_reset <= 1'b0;
      end else begin
         current_alarm_out <= current_alarm & ~shutdown_nxt;
         current_dac_one_hiz <= shutdown_nxt &
            (spare_dac_assignment != fasc_pkg::fasc_spare_current_one);
         current_dac_two_hiz <= shutdown_nxt;
         voltage_dac_clamp <= shutdown_nxt &
            (spare_dac_assignment != fasc_pkg::fasc_spare_voltage);
         feed_forward_update <= 1'b1;
         feedback_hold <= shutdown_nxt;
         feedback_reset <= dis_release & fault_shutdown_r;
      end
   end

   assign tx_fault = tx_fault_r;
   assign shutdown = shutdown_r;

   // Helper: cycles since a qualifying ext alarm one level appeared
   logic [7:0] ext1_wait_r;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ext1_wait_r <= 8'h00;
      end else if ((external_alarm_one ^ ext_alarm_one_polarity) && !status_r[2]) begin
         ext1_wait_r <= (ext1_wait_r == 8'hFF) ? 8'hFF : ext1_wait_r + 8'h01;
      end else begin
         ext1_wait_r <= 8'h00;
      end
   end

   property p_ext_detect;
      @(posedge clk) disable iff (!rst_n)
      ext1_wait_r <= 8'(fasc_pkg::EXT_DETECT_CYCLES);
   endproperty
   a_ext_detect: assert property (p_ext_detect) else $error("ext alarm one too slow");

   property p_ext2_gate;
      @(posedge clk) disable iff (!rst_n)
      (power_leveling_one_enable && sfp_support_select && !ext1_alarm && !optical_alarm &&
       !current_alarm && !temperature_alarm) |=> !tx_fault;
   endproperty
   a_ext2_gate: assert property (p_ext2_gate) else $error("ext alarm two not gated");

   property p_status_set;
      @(posedge clk) disable iff (!rst_n)
      |alarms |=> ((status_r[4:0] & $past(alarms)) == $past(alarms));
   endproperty
   a_status_set: assert property (p_status_set) else $error("status bit not set");

   property p_follow;
      @(posedge clk) disable iff (!rst_n)
      sfp_support_select |=> (tx_fault == $past(fault_any));
   endproperty
   a_follow: assert property (p_follow) else $error("fault does not follow");

   property p_latch;
      @(posedge clk) disable iff (!rst_n)
      (!sfp_support_select && fault_any && !dis_s && !dis_d_r) ##1 !sfp_support_select
      |-> tx_fault;
   endproperty
   a_latch: assert property (p_latch) else $error("fault not latched");

   property p_freeze;
      @(posedge clk) disable iff (!rst_n)
      (!sfp_support_select && dis_s && dis_d_r) ##1 !sfp_support_select
      |-> tx_fault == $past(tx_fault);
   endproperty
   a_freeze: assert property (p_freeze) else $error("fault changed under disable");

   property p_release;
      @(posedge clk) disable iff (!rst_n)
      (!sfp_support_select && dis_d_r && !dis_s) |=> !tx_fault;
   endproperty
   a_release: assert property (p_release) else $error("release kept fault");

   property p_disable_sd;
      @(posedge clk) disable iff (!rst_n)
      dis_s |=> shutdown && current_dac_two_hiz && !current_alarm_out;
   endproperty
   a_disable_sd: assert property (p_disable_sd) else $error("disable not obeyed");

   property p_adjust;
      @(posedge clk) disable iff (!rst_n)
      (adjustment_mode && !dis_s) |=> !shutdown;
   endproperty
   a_adjust: assert property (p_adjust) else $error("fault shutdown in adjust");

   property p_spare;
      @(posedge clk) disable iff (!rst_n)
      (spare_dac_assignment == fasc_pkg::fasc_spare_voltage) |=> !voltage_dac_clamp;
   endproperty
   a_spare: assert property (p_spare) else $error("spare DAC shut down");

   property p_spare_one;
      @(posedge clk) disable iff (!rst_n)
      (spare_dac_assignment == fasc_pkg::fasc_spare_current_one) |=> !current_dac_one_hiz;
   endproperty
   a_spare_one: assert property (p_spare_one) else $error("spare current DAC floated");

   property p_clamp;
      @(posedge clk) disable iff (!rst_n)
      (dis_s && spare_dac_assignment == fasc_pkg::fasc_spare_current_one)
      |=> voltage_dac_clamp;
   endproperty
   a_clamp: assert property (p_clamp) else $error("voltage DAC not clamped");

   property p_fault_sd;
      @(posedge clk) disable iff (!rst_n)
      (!sfp_support_select && fault_latch_r && !dis_d_r && !adjustment_mode) |=> shutdown;
   endproperty
   a_fault_sd: assert property (p_fault_sd) else $error("latched fault no shutdown");

   property p_fb_pulse;
      @(posedge clk) disable iff (!rst_n)
      feedback_reset |=> !feedback_reset;
   endproperty
   a_fb_pulse: assert property (p_fb_pulse) else $error("feedback reset too long");

   property p_ff;
      @(posedge clk) disable iff (!rst_n)
      1'b1 |=> feed_forward_update;
   endproperty
   a_ff: assert property (p_ff) else $error("feed-forward update stopped");

   c_fault_sd: cover property (@(posedge clk) disable iff (!rst_n)
      !sfp_support_select && fault_any ##[1:3] shutdown);
   c_release: cover property (@(posedge clk) disable iff (!rst_n)
      tx_fault && !sfp_support_select ##[1:20] feedback_reset);
   c_follow: cover property (@(posedge clk) disable iff (!rst_n)
      sfp_support_select && tx_fault ##1 !tx_fault);
endmodule

// file: fasc_host_model.sv
// Purpose: Host and external alarm source model
// Assumes: Bench asks for pin levels through the req inputs
// Notes: Pins move by non-blocking update on the rising edge, so no race with the bench
module fasc_host_model (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic dis_req,
   input wire logic alm1_req,
   input wire logic alm2_req,
   output logic tx_disable,
   output logic external_alarm_one,
   output logic modulation_control_pin
);
   timeunit 1ns;
   timeprecision 1ns;
   // Host raises disable to ask for shutdown; sources drive alarm pins
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         tx_disable <= 1'b0;
         external_alarm_one <= 1'b0;
         modulation_control_pin <= 1'b0;
      end else begin
         tx_disable <= dis_req;
         external_alarm_one <= alm1_req;
         modulation_control_pin <= alm2_req;
      end
   end
endmodule

// file: fasc_top_tb_top.sv
// Purpose: Self-checking bench for fault and shutdown control
// Assumes: Inputs change on the falling edge of clk
// Notes: Waits are fixed counts taken from the pin latency
module fasc_top_tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic dis = 1'b0, a1 = 1'b0, a2 = 1'b0, txd, p1, p2;
   logic opt = 1'b0, cur = 1'b0, tmp = 1'b0, pol1 = 1'b0, pol2 = 1'b0;
   logic plv = 1'b0, sfp = 1'b1, adj = 1'b0, wr = 1'b0, rd = 1'b0;
   fasc_pkg::fasc_spare_type spare = fasc_pkg::fasc_spare_current_one;
   logic [7:0] addr = 8'h00, wdata = 8'h00, rdata;
   logic flt, sd, cur_out, hiz1, hiz2, clamp, ffu, fbh, fbr;
   int error_cnt = 0;
   int check_count = 0;
   int n;
   // Clock
   always #50 clk = ~clk;
   fasc_host_model fasc_host_model_i (.clk(clk), .rst_n(rst_n), .dis_req(dis),
      .alm1_req(a1), .alm2_req(a2), .tx_disable(txd), .external_alarm_one(p1),
      .modulation_control_pin(p2));
   fasc_top fasc_top_i (.clk(clk), .rst_n(rst_n), .tx_disable(txd),
      .external_alarm_one(p1), .modulation_control_pin(p2), .optical_alarm(opt),
      .current_alarm(cur), .temperature_alarm(tmp), .ext_alarm_one_polarity(pol1),
      .ext_alarm_two_polarity(pol2), .power_leveling_one_enable(plv),
      .sfp_support_select(sfp), .adjustment_mode(adj), .spare_dac_assignment(spare),
      .reg_addr(addr), .reg_wdata(wdata), .reg_wr(wr), .reg_rd(rd), .reg_rdata(rdata),
      .tx_fault(flt), .shutdown(sd), .current_alarm_out(cur_out),
      .current_dac_one_hiz(hiz1), .current_dac_two_hiz(hiz2), .voltage_dac_clamp(clamp),
      .feed_forward_update(ffu), .feedback_hold(fbh), .feedback_reset(fbr));
   // Comparison helpers
   task automatic chk(input string s, input logic [7:0] e, input logic [7:0] g);
      check_count++;
      if (g !== e) begin
         error_cnt++;
         $display("Error %s expected %h seen %h", s, e, g);
      end
   endtask
   task automatic chk_bit(input string s, input logic e, input logic g);
      chk(s, {7'h00, e}, {7'h00, g});
   endtask
   task automatic cyc(input int c);
      repeat (c) @(negedge clk);
   endtask
   // Register port cycles
   task automatic wreg(input logic [7:0] a, input logic [7:0] d);
      @(negedge clk);
      addr = a;
      wdata = d;
      wr = 1'b1;
      @(negedge clk);
      wr = 1'b0;
   endtask
   task automatic rchk(input logic [7:0] a, input logic [7:0] e);
      @(negedge clk);
      addr = a;
      rd = 1'b1;
      @(negedge clk);
      rd = 1'b0;
      chk("reg_rdata", e, rdata);
   endtask
   task automatic give_verdict();
      $display("Checks %0d errors %0d", check_count, error_cnt);
      if (error_cnt == 0 && check_count > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   // Reset values, unmapped and read-only places
   task automatic t_regs();
      rchk(8'h05, 8'h00);
      rchk(8'h06, 8'h00);
      rchk(8'h33, 8'h00);
      wreg(8'h19, 8'hFF);
      rchk(8'h19, 8'h00);
      chk_bit("ff_update", 1'b1, ffu);
   endtask
   // Non-latching fault, mask selection
   task automatic t_follow();
      wreg(8'h05, 8'h08);
      opt = 1'b1;
      cyc(3);
      chk_bit("tx_fault", 1'b0, flt);
      cur = 1'b1;
      cyc(3);
      chk_bit("tx_fault", 1'b1, flt);
      chk_bit("shutdown", 1'b0, sd);
      chk_bit("cur_out", 1'b1, cur_out);
      cur = 1'b0;
      opt = 1'b0;
      cyc(3);
      chk_bit("tx_fault", 1'b0, flt);
      rchk(8'h19, 8'h03);
      rchk(8'h19, 8'h00);
   endtask
   // Pin polarity and shared pin modes
   task automatic t_pins();
      wreg(8'h05, 8'h30);
      for (int p = 0; p < 2; p++) begin
         pol1 = p[0];
         a1 = ~p[0];
         cyc(6);
         chk_bit("tx_fault", 1'b1, flt);
         a1 = p[0];
         cyc(6);
         chk_bit("tx_fault", 1'b0, flt);
      end
      pol2 = 1'b1;
      plv = 1'b1;
      cyc(6);
      chk_bit("tx_fault", 1'b0, flt);
      plv = 1'b0;
      cyc(6);
      chk_bit("tx_fault", 1'b1, flt);
      pol2 = 1'b0;
      cyc(6);
      rchk(8'h19, 8'h0C);
   endtask
   // Latched fault, disable hold and release
   task automatic t_latch();
      wreg(8'h05, 8'h00);
      wreg(8'h06, 8'h80);
      sfp = 1'b0;
      cur = 1'b1;
      tmp = 1'b1;
      cyc(2);
      tmp = 1'b0;
      cyc(2);
      chk_bit("tx_fault", 1'b1, flt);
      chk_bit("shutdown", 1'b1, sd);
      chk({"dacs"}, 8'h03, {5'h00, hiz1, hiz2, clamp});
      chk_bit("cur_out", 1'b0, cur_out);
      chk_bit("fb_hold", 1'b1, fbh);
      dis = 1'b1;
      tmp = 1'b1;
      cyc(6);
      chk_bit("tx_fault", 1'b1, flt);
      rchk(8'h19, 8'h12);
      tmp = 1'b0;
      dis = 1'b0;
      n = 0;
      repeat (8) begin
         @(negedge clk);
         n += int'(fbr === 1'b1);
      end
      chk("fb_reset", 8'h01, 8'(n));
      chk_bit("tx_fault", 1'b0, flt);
      chk_bit("shutdown", 1'b0, sd);
      dis = 1'b1;
      cyc(4);
      tmp = 1'b1;
      spare = fasc_pkg::fasc_spare_voltage;
      cyc(3);
      chk_bit("tx_fault", 1'b0, flt);
      chk_bit("shutdown", 1'b1, sd);
      chk("dacs", 8'h06, {5'h00, hiz1, hiz2, clamp});
      chk_bit("ff_update", 1'b1, ffu);
      tmp = 1'b0;
      cur = 1'b0;
      dis = 1'b0;
      cyc(6);
   endtask
   // Adjustment mode keeps the DACs running
   task automatic t_adjust();
      adj = 1'b1;
      tmp = 1'b1;
      cyc(3);
      chk_bit("tx_fault", 1'b1, flt);
      chk_bit("shutdown", 1'b0, sd);
   endtask
   // Main sequence
   initial begin
      cyc(16);
      rst_n = 1'b1;
      cyc(2);
      t_regs();
      t_follow();
      t_pins();
      t_latch();
      t_adjust();
      give_verdict();
   end
endmodule
